// >>> diag_pkg.sv
/*
  Constants shared by the diagnostic monitor: register map, field positions,
  reset values, CRC polynomials, frame lengths and timing counts.
  Assumes a 125 MHz core clock; counts are derived from that rate.
*/
// Functional notes
// - Any reset pulse sets reset-seen flag
// - Reset-seen clears only on status read
// - Level checks enabled per channel at 0x25
// - Overvoltage sets sticky bit in 0x26
// - Undervoltage sets sticky bit in 0x27
// - Errors raise flags in status header
// - Logic fault is OR of 0x22 bits
// - Trim load CRC mismatch sets bit 0
// - Trim check on after reset, bit 0
// - Map check off after reset, bit 1
// - Map CRC rechecked every 4 us
// - Every register write refreshes map reference
// - Data CRC16 plain division, zero init
// - CRC16 appended per output line, bit 2
// - Two lines: 64-bit each; one: 128
// - Register reads with CRC: 24-bit frames
// - Bad write CRC sets bit 2 of 0x22
// - Parallel bus gets one 128-bit CRC
// - Bit 7 forces fixed check patterns
// - Invalid read sets bit 4 when enabled
// - Invalid or read-only write sets bit 3 when enabled
// - Status header layout, eight bits per channel
// - Conversion over 4 us: partial reset, bit 5
package diag_pkg;

  localparam logic [5:0] ADDR_EXIT     = 6'h00;
  localparam logic [5:0] ADDR_STATUS   = 6'h01;
  localparam logic [5:0] ADDR_LOGIC_EN = 6'h21;
  localparam logic [5:0] ADDR_FAULT    = 6'h22;
  localparam logic [5:0] ADDR_LEVEL_EN = 6'h25;
  localparam logic [5:0] ADDR_OVER     = 6'h26;
  localparam logic [5:0] ADDR_UNDER    = 6'h27;

  // Bit positions in the enable register; all but BIT_PATTERN are shared by the fault register
  localparam int BIT_TRIM    = 0;
  localparam int BIT_MAP     = 1;
  localparam int BIT_LINK    = 2;
  localparam int BIT_BAD_WR  = 3;
  localparam int BIT_BAD_RD  = 4;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_PATTERN = 7;

  localparam logic [7:0] LOGIC_EN_RESET = 8'h01;
  localparam logic [7:0] LEVEL_EN_RESET = 8'h00;

  localparam logic [15:0] CRC16_POLY = 16'h755b;
  localparam logic [7:0]  CRC8_POLY  = 8'h07;

  localparam int FRAME_SHORT = 16;
  localparam int FRAME_LONG  = 24;

  localparam logic [127:0] CHECK_PATTERN = {16'hacca, 16'h5cc5, 16'ha33a, 16'h5335,
                                            16'hcaac, 16'hc55c, 16'h3aa3, 16'h3553};

  localparam int CLK_MHZ        = 125;
  localparam int TCONV_NS       = 4000;
  localparam int TCONV_CYC      = (TCONV_NS * CLK_MHZ + 999) / 1000;
  localparam int MAP_PERIOD_NS  = 4000;
  localparam int MAP_PERIOD_CYC = (MAP_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int CNT_W          = 10;

  // CRC8 of a 16-bit register frame, MSB first, zero start
  function automatic logic [7:0] crc8_of(input logic [15:0] d);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC8_POLY : 8'h00);
    end
    return c;
  endfunction

endpackage

// >>> bit_sync.sv
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a level that holds for several destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt.meta   = d_i;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.stable;
endmodule // bit_sync
`default_nettype wire

// >>> crc16_unit.sv
/*
  Combinational CRC16 over a W-bit word, first bit at the MSB.
  Assumes the caller registers the result; long words make a deep cone.
*/
`timescale 1ns/1ps
`default_nettype none
module crc16_unit
  import diag_pkg::*;
#(
  parameter int W = 128
) (
  input  wire logic [W-1:0] data_i,
  output logic      [15:0]  crc_o
);
  logic [15:0] c;
  logic        fb;

  // Shift-register form equals long division of data followed by 16 zeros
  always_comb begin
    c  = 16'h0000;
    fb = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      fb = c[15] ^ data_i[i];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
    end
    crc_o = c;
  end
endmodule // crc16_unit
`default_nettype wire

// >>> diag_monitor.sv
/*
  Diagnostic monitor: reset detection, level flags, logic fault details,
  trim and map CRC checks, conversion timeout, link CRC on data and register
  frames, and the fixed-pattern check. Register frames arrive on the serial
  link clocked by sclk_i; the rest runs on mclk_i.
  Assumes the host leaves at least four mclk periods between register frames
  so the frame event and readback word settle across domains.
*/
`timescale 1ns/1ps
`default_nettype none
module diag_monitor
  import diag_pkg::*;
#(
  parameter int TRIM_W = 64
) (
  // Core clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // Serial link
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              sdi_i,
  output logic                   dout_a_o,
  // Pins and analog comparators
  input  wire logic              busy_i,
  input  wire logic              reset_pulse_i,
  input  wire logic              open_any_i,
  input  wire logic [7:0]        over_level_i,
  input  wire logic [7:0]        under_level_i,
  // Trim load
  input  wire logic              trim_done_i,
  input  wire logic [TRIM_W-1:0] trim_data_i,
  input  wire logic [15:0]       trim_crc_i,
  // Conversion results
  input  wire logic              conv_done_i,
  input  wire logic [127:0]      conv_data_i,
  input  wire logic              status_hdr_en_i,
  output logic                   result_valid_o,
  output logic      [127:0]      result_o,
  output logic      [63:0]       header_o,
  output logic      [15:0]       crc_all_o,
  output logic      [15:0]       crc_line_a_o,
  output logic      [15:0]       crc_line_b_o,
  // Status
  output logic                   partial_reset_o,
  output logic                   reg_mode_o
);

  typedef struct packed {
    logic [4:0]  cnt;
    logic [22:0] sh_in;
    logic [22:0] sh_out;
    logic        dout;
  } frame_t;

  typedef struct packed {
    logic [23:0] hold;
    logic        tog;
  } catch_t;

  typedef struct packed {
    logic             reset_seen;
    logic [7:0]       logic_en, level_en, fault, over, under;
    logic [5:0]       rd_addr;
    logic [15:0]      rd_word;
    logic             rd_pend;
    logic             reg_mode;
    logic             tog_d;
    logic             wr_d;
    logic             map_en_d;
    logic [15:0]      map_ref;
    logic [CNT_W-1:0] map_cnt;
    logic [CNT_W-1:0] busy_cnt;
    logic             tripped, part_rst, rst_pin_d, res_valid;
    logic [127:0]     result;
    logic [63:0]      header;
    logic [15:0]      crc_all, crc_a, crc_b;
  } core_t;

  frame_t fr_r;
  frame_t fr_nxt;
  catch_t ct_r;
  catch_t ct_nxt;
  core_t  c_r;
  core_t  c_nxt;

  logic        crc_on_l;
  logic [4:0]  last_bit;
  logic [19:0] syn_q;
  logic [7:0]  over_s, under_s;
  logic        open_s, rst_s, busy_s, tog_s;
  logic [127:0] src;
  logic [15:0] crc_all_w, crc_a_w, crc_b_w, trim_crc_w, map_crc_w;
  logic        evt, long_frm;
  logic [15:0] cmd;
  logic        crc_bad;
  logic [7:0]  status_now, fset, fclr, oclr, uclr;
  logic        wrote, status_rd, timeout_hit;

  function automatic logic readable(input logic [5:0] a);
    return (a == ADDR_STATUS) || (a == ADDR_LOGIC_EN) || (a == ADDR_FAULT) ||
           (a == ADDR_LEVEL_EN) || (a == ADDR_OVER) || (a == ADDR_UNDER);
  endfunction

  function automatic logic writable(input logic [5:0] a);
    return (a == ADDR_EXIT) || (a == ADDR_LOGIC_EN) || (a == ADDR_FAULT) ||
           (a == ADDR_LEVEL_EN) || (a == ADDR_OVER) || (a == ADDR_UNDER);
  endfunction

  function automatic logic [7:0] reg_value(input logic [5:0] a, input core_t s, input logic [7:0] st);
    case (a)
      ADDR_STATUS:   return st;
      ADDR_LOGIC_EN: return s.logic_en;
      ADDR_FAULT:    return s.fault;
      ADDR_LEVEL_EN: return s.level_en;
      ADDR_OVER:     return s.over;
      ADDR_UNDER:    return s.under;
      default:       return 8'h00;
    endcase
  endfunction

  // Link domain: frame shifter, reset by chip select between frames
  bit_sync #(.W(1)) u_sync_link (
    .clk_i   (sclk_i),
    .reset_i (1'b0),
    .d_i     (c_r.logic_en[BIT_LINK]),
    .q_o     (crc_on_l)
  );

  always_comb begin
    fr_nxt       = fr_r;
    ct_nxt       = ct_r;
    last_bit     = crc_on_l ? 5'(FRAME_LONG - 1) : 5'(FRAME_SHORT - 1);
    fr_nxt.sh_in = {fr_r.sh_in[21:0], sdi_i};
    if (fr_r.cnt == 5'd0) begin
      {fr_nxt.dout, fr_nxt.sh_out} = {c_r.rd_word, crc8_of(c_r.rd_word)};
    end else begin
      fr_nxt.dout   = fr_r.sh_out[22];
      fr_nxt.sh_out = {fr_r.sh_out[21:0], 1'b0};
    end
    if (fr_r.cnt == last_bit) begin
      fr_nxt.cnt  = 5'd0;
      ct_nxt.hold = crc_on_l ? {fr_r.sh_in, sdi_i} : {8'h00, fr_r.sh_in[14:0], sdi_i};
      ct_nxt.tog  = ~ct_r.tog;
    end else begin
      fr_nxt.cnt = fr_r.cnt + 5'd1;
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fr_r <= '0;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // Captured frame survives chip select; only the full reset clears it
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      ct_r <= '0;
    end else begin
      ct_r <= ct_nxt;
    end
  end

  assign dout_a_o = fr_r.dout;

  // Core domain
  bit_sync #(.W(20)) u_sync_core (
    .clk_i   (mclk_i),
    .reset_i (reset_i),
    .d_i     ({ct_r.tog, busy_i, reset_pulse_i, open_any_i, over_level_i, under_level_i}),
    .q_o     (syn_q)
  );

  assign tog_s   = syn_q[19];
  assign busy_s  = syn_q[18];
  assign rst_s   = syn_q[17];
  assign open_s  = syn_q[16];
  assign over_s  = syn_q[15:8];
  assign under_s = syn_q[7:0];

  assign src = c_r.logic_en[BIT_PATTERN] ? CHECK_PATTERN : conv_data_i;

  crc16_unit #(.W(128)) u_crc_all (.data_i(src), .crc_o(crc_all_w));
  crc16_unit #(.W(64)) u_crc_a (.data_i(src[127:64]), .crc_o(crc_a_w));
  crc16_unit #(.W(64)) u_crc_b (.data_i(src[63:0]), .crc_o(crc_b_w));
  crc16_unit #(.W(TRIM_W)) u_crc_trim (.data_i(trim_data_i), .crc_o(trim_crc_w));
  crc16_unit #(.W(16)) u_crc_map (.data_i({c_r.logic_en, c_r.level_en}), .crc_o(map_crc_w));

  always_comb begin
    c_nxt       = c_r;
    fset        = 8'h00;
    fclr        = 8'h00;
    oclr        = 8'h00;
    uclr        = 8'h00;
    wrote       = 1'b0;
    status_rd   = 1'b0;
    timeout_hit = 1'b0;
    status_now  = {c_r.reset_seen, |c_r.fault, open_s, |c_r.over, |c_r.under, 3'b000};

    // Register frame decode
    evt          = tog_s ^ c_r.tog_d;
    c_nxt.tog_d  = tog_s;
    long_frm     = c_r.logic_en[BIT_LINK];
    cmd          = long_frm ? ct_r.hold[23:8] : ct_r.hold[15:0];
    crc_bad      = long_frm && (crc8_of(cmd) != ct_r.hold[7:0]);
    c_nxt.rd_pend = 1'b0;
    if (c_r.rd_pend) begin
      c_nxt.rd_word = {2'b00, c_r.rd_addr, reg_value(c_r.rd_addr, c_r, status_now)};
    end
    if (evt && !cmd[15]) begin
      c_nxt.rd_addr = cmd[13:8];
      if (cmd[14]) begin
        c_nxt.reg_mode = 1'b1;
        c_nxt.rd_word  = {2'b00, cmd[13:8], reg_value(cmd[13:8], c_r, status_now)};
        status_rd      = (cmd[13:8] == ADDR_STATUS);
        if (!readable(cmd[13:8]) && c_r.logic_en[BIT_BAD_RD]) begin
          fset[BIT_BAD_RD] = 1'b1;
        end
      end else if (crc_bad) begin
        fset[BIT_LINK] = 1'b1;
      end else if (!writable(cmd[13:8])) begin
        fset[BIT_BAD_WR] = c_r.logic_en[BIT_BAD_WR];
      end else begin
        wrote         = 1'b1;
        c_nxt.rd_pend = 1'b1;
        case (cmd[13:8])
          ADDR_EXIT:     c_nxt.reg_mode = 1'b0;
          ADDR_LOGIC_EN: c_nxt.logic_en = cmd[7:0];
          ADDR_FAULT:    fclr = cmd[7:0];
          ADDR_LEVEL_EN: c_nxt.level_en = cmd[7:0];
          ADDR_OVER:     oclr = cmd[7:0];
          ADDR_UNDER:    uclr = cmd[7:0];
          default:       wrote = 1'b0;
        endcase
      end
    end

    // Trim store check, only on the load strobe
    if (trim_done_i && c_r.logic_en[BIT_TRIM] && (trim_crc_w != trim_crc_i)) begin
      fset[BIT_TRIM] = 1'b1;
    end

    // Map check: reference taken on enable and after every write
    c_nxt.map_en_d = c_r.logic_en[BIT_MAP];
    c_nxt.wr_d     = wrote;
    if (c_r.wr_d || (c_r.logic_en[BIT_MAP] && !c_r.map_en_d)) begin
      c_nxt.map_ref = map_crc_w;
    end
    if (!c_r.logic_en[BIT_MAP] || c_r.wr_d) begin
      c_nxt.map_cnt = '0;
    end else if (c_r.map_cnt == CNT_W'(MAP_PERIOD_CYC - 1)) begin
      c_nxt.map_cnt = '0;
      fset[BIT_MAP] = (map_crc_w != c_r.map_ref);
    end else begin
      c_nxt.map_cnt = c_r.map_cnt + 1'b1;
    end

    // Conversion timeout; counting restarts with each busy period
    c_nxt.part_rst = 1'b0;
    if (!busy_s) begin
      c_nxt.busy_cnt = '0;
      c_nxt.tripped  = 1'b0;
    end else if (!c_r.tripped) begin
      if (c_r.busy_cnt == CNT_W'(TCONV_CYC)) begin
        c_nxt.tripped = 1'b1;
        if (c_r.logic_en[BIT_TIMEOUT]) begin
          timeout_hit        = 1'b1;
          fset[BIT_TIMEOUT]  = 1'b1;
          c_nxt.part_rst     = 1'b1;
        end
      end else begin
        c_nxt.busy_cnt = c_r.busy_cnt + 1'b1;
      end
    end

    // Set wins over clear in the same cycle
    c_nxt.rst_pin_d  = rst_s;
    c_nxt.reset_seen = (c_r.reset_seen && !status_rd) || (rst_s && !c_r.rst_pin_d) || timeout_hit;
    c_nxt.fault      = (c_r.fault & ~fclr) | fset;
    c_nxt.fault[BIT_BAD_WR] = c_nxt.fault[BIT_BAD_WR] & c_nxt.logic_en[BIT_BAD_WR];
    c_nxt.fault[BIT_BAD_RD] = c_nxt.fault[BIT_BAD_RD] & c_nxt.logic_en[BIT_BAD_RD];
    c_nxt.over  = ((c_r.over & ~oclr) | (over_s & c_r.level_en)) & c_nxt.level_en;
    c_nxt.under = ((c_r.under & ~uclr) | (under_s & c_r.level_en)) & c_nxt.level_en;

    // Conversion result, header and data CRC
    c_nxt.res_valid = conv_done_i;
    if (conv_done_i) begin
      c_nxt.result  = src;
      c_nxt.crc_all = long_frm ? crc_all_w : 16'h0000;
      c_nxt.crc_a   = long_frm ? crc_a_w : 16'h0000;
      c_nxt.crc_b   = long_frm ? crc_b_w : 16'h0000;
      for (int k = 0; k < 8; k++) begin
        c_nxt.header[63 - 8 * k -: 8] = status_hdr_en_i ?
          {c_r.reset_seen, |c_r.fault, open_s, c_r.over[k], c_r.under[k], 3'(k)} : 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      c_r            <= '0;
      c_r.reset_seen <= 1'b1;
      c_r.logic_en   <= LOGIC_EN_RESET;
      c_r.level_en   <= LEVEL_EN_RESET;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign result_valid_o  = c_r.res_valid;
  assign result_o        = c_r.result;
  assign header_o        = c_r.header;
  assign crc_all_o       = c_r.crc_all;
  assign crc_line_a_o    = c_r.crc_a;
  assign crc_line_b_o    = c_r.crc_b;
  assign partial_reset_o = c_r.part_rst;
  assign reg_mode_o      = c_r.reg_mode;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  a_seen_holds: assert property (c_r.reset_seen && !status_rd |=> c_r.reset_seen)
    else $error("reset-seen flag dropped without a status read");
  a_timeout_resets: assert property (timeout_hit |=> c_r.part_rst && c_r.reset_seen && c_r.fault[BIT_TIMEOUT])
    else $error("timeout did not raise partial reset and flags");
  a_timeout_count: assert property ($rose(c_r.part_rst) |-> $past(c_r.busy_cnt) == CNT_W'(TCONV_CYC))
    else $error("partial reset at wrong busy count");
  a_over_sets: assert property (over_s[0] && c_r.level_en[0] && !(evt && !cmd[15] && !cmd[14] && cmd[13:8] == ADDR_LEVEL_EN)
                                |=> c_r.over[0])
    else $error("overvoltage flag not set");
  a_under_sets: assert property (under_s[7] && c_r.level_en[7] && !(evt && !cmd[15] && !cmd[14] && cmd[13:8] == ADDR_LEVEL_EN)
                                 |=> c_r.under[7])
    else $error("undervoltage flag not set");
  a_level_off: assert property (!c_r.level_en[0] |-> !c_r.over[0] && !c_r.under[0])
    else $error("level flag kept while check disabled");
  a_header_fault: assert property (conv_done_i && status_hdr_en_i |=> c_r.header[62] == $past(|c_r.fault))
    else $error("header fault bit differs from detail OR");
  a_trim_check: assert property (trim_done_i && c_r.logic_en[BIT_TRIM] && trim_crc_w != trim_crc_i |=> c_r.fault[BIT_TRIM])
    else $error("trim mismatch not flagged");
  a_enable_reset: assert property ($fell(reset_i) |-> c_r.logic_en == LOGIC_EN_RESET)
    else $error("enable register wrong after reset");
  a_map_refresh: assert property (c_r.wr_d |=> c_r.map_ref == $past(map_crc_w))
    else $error("map reference not refreshed after write");
  a_map_period: assert property (c_r.map_cnt < CNT_W'(MAP_PERIOD_CYC))
    else $error("map check counter overran its period");
  a_write_crc: assert property (evt && !cmd[15] && !cmd[14] && crc_bad |=> c_r.fault[BIT_LINK])
    else $error("bad write CRC not flagged");
  a_bad_read: assert property (evt && !cmd[15] && cmd[14] && !readable(cmd[13:8]) && c_r.logic_en[BIT_BAD_RD]
                               |=> c_r.fault[BIT_BAD_RD])
    else $error("invalid read not flagged");
  a_bad_write: assert property (evt && !cmd[15] && !cmd[14] && !crc_bad && !writable(cmd[13:8])
                                && c_r.logic_en[BIT_BAD_WR] |=> c_r.fault[BIT_BAD_WR])
    else $error("invalid write not flagged");
  a_pattern_out: assert property (conv_done_i && c_r.logic_en[BIT_PATTERN] |=> c_r.result[127:112] == 16'hacca)
    else $error("check pattern not forced");

endmodule // diag_monitor
`default_nettype wire

// >>> host_model.sv
/*
  Host controller model: sends register frames on the serial link and
  collects what the device shifts out on dout.
  Assumes the bench calls xfer one frame at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Serial link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic dout_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  function automatic logic [7:0] c8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // Clock runs only inside the frame; bad spoils the check byte on purpose
  task automatic xfer(input logic [15:0] w, input logic lng, input logic bad, output logic [23:0] got);
    logic [23:0] f;
    f = {w, c8(w) ^ {8{bad}}};
    got = '0;
    cs_n_o = 1'b0;
    for (int i = 23; i >= (lng ? 0 : 8); i--) begin
      sdi_o = f[i];
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
      got = {got[22:0], dout_i};
    end
    cs_n_o = 1'b1;
    // Released line shows the inverse so stale data is never mistaken
    sdi_o = ~sdi_o;
    #120;
  endtask
endmodule // host_model
`default_nettype wire

// >>> diagnostic_monitor_crc_flags_test.sv
/*
  Bench for diag_monitor: register rows, then level flags, trim check,
  link CRC, pattern mode, bad write CRC, timeout and reset pulse.
  Assumes host_model drives the serial link.
*/
`timescale 1ns/1ps
`default_nettype none
module diagnostic_monitor_crc_flags_test;
  import diag_pkg::*;
  typedef struct packed {logic w; logic [5:0] a; logic [7:0] d;} op_t;
  localparam logic [127:0] DAT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic         sclk, cs_n, sdi, dout, busy, rp, opn, trim_done, conv_done, hdr_en;
  logic         rv, pr, rm, lng;
  logic [7:0]   ovr, und, v;
  logic [15:0]  trim_crc, ca, cla, clb;
  logic [63:0]  trim_data, hdr;
  logic [127:0] conv_data, res;
  logic [23:0]  got;
  int           n_errors = 0;
  int           checked = 0;
  int           npr = 0;
  // Rows enable the map check and then rewrite the map, as a host must
  op_t          ops [17] = '{'{1'b0, 6'h01, 8'h80}, '{1'b0, 6'h01, 8'h00}, '{1'b0, 6'h21, 8'h01},
    '{1'b0, 6'h25, 8'h00}, '{1'b1, 6'h25, 8'hff}, '{1'b0, 6'h25, 8'hff}, '{1'b1, 6'h21, 8'h1b},
    '{1'b0, 6'h21, 8'h1b}, '{1'b1, 6'h01, 8'h55}, '{1'b0, 6'h3f, 8'h00}, '{1'b0, 6'h22, 8'h18},
    '{1'b0, 6'h01, 8'h40}, '{1'b1, 6'h22, 8'h08}, '{1'b1, 6'h22, 8'h00}, '{1'b0, 6'h22, 8'h10},
    '{1'b1, 6'h21, 8'h0b}, '{1'b0, 6'h22, 8'h00}};

  host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .dout_i(dout));

  diag_monitor dut (.mclk_i(mclk), .reset_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .dout_a_o(dout), .busy_i(busy), .reset_pulse_i(rp), .open_any_i(opn), .over_level_i(ovr),
    .under_level_i(und), .trim_done_i(trim_done), .trim_data_i(trim_data), .trim_crc_i(trim_crc),
    .conv_done_i(conv_done), .conv_data_i(conv_data), .status_hdr_en_i(hdr_en),
    .result_valid_o(rv), .result_o(res), .header_o(hdr), .crc_all_o(ca), .crc_line_a_o(cla),
    .crc_line_b_o(clb), .partial_reset_o(pr), .reg_mode_o(rm));

  always #4 mclk = ~mclk;
  always @(posedge mclk) if (pr === 1'b1) npr++;

  function automatic logic [15:0] c16(input logic [127:0] d, input int n);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC16_POLY : 16'h0000);
    return c;
  endfunction

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic bad);
    host.xfer({2'b00, a, d}, lng, bad, got);
    @(posedge mclk);
  endtask

  // Readback of a frame shows up in the following frame
  task automatic rd(input logic [5:0] a, output logic [7:0] val);
    host.xfer({2'b01, a, 8'h00}, lng, 1'b0, got);
    host.xfer({2'b01, ADDR_LOGIC_EN, 8'h00}, lng, 1'b0, got);
    if (lng) chk(got[7:0], host.c8(got[23:8]));
    val = lng ? got[15:8] : got[7:0];
    @(posedge mclk);
  endtask

  task automatic conv(input logic [127:0] d);
    @(posedge mclk);
    conv_data <= d;
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    @(negedge mclk);
    chk(rv, 1'b1);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge mclk);
    n_errors++;
    end_sim;
  end

  initial begin
    {busy, rp, opn, trim_done, conv_done, hdr_en, lng} = '0;
    {ovr, und, trim_data, trim_crc, conv_data} = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    foreach (ops[i]) begin
      if (ops[i].w) wr(ops[i].a, ops[i].d, 1'b0);
      else begin
        rd(ops[i].a, v);
        chk(v, ops[i].d);
      end
    end
    ovr <= 8'h05;
    und <= 8'h80;
    repeat (6) @(posedge mclk);
    ovr <= 8'h00;
    und <= 8'h00;
    opn <= 1'b1;
    hdr_en <= 1'b1;
    rd(ADDR_OVER, v);
    chk(v, 8'h05);
    rd(ADDR_UNDER, v);
    chk(v, 8'h80);
    rd(ADDR_STATUS, v);
    chk(v, 8'h38);
    conv(DAT);
    chk(hdr[63:59], 5'h06);
    chk(hdr[7:0], 8'h2f);
    chk(ca, 16'h0000);
    opn <= 1'b0;
    wr(ADDR_OVER, 8'h05, 1'b0);
    rd(ADDR_OVER, v);
    chk(v, 8'h00);
    wr(ADDR_LEVEL_EN, 8'h00, 1'b0);
    rd(ADDR_UNDER, v);
    chk(v, 8'h00);
    trim_data <= 64'h0123456789abcdef;
    trim_crc <= ~c16({64'h0, 64'h0123456789abcdef}, 64);
    trim_done <= 1'b1;
    @(posedge mclk);
    trim_done <= 1'b0;
    rd(ADDR_FAULT, v);
    chk(v, 8'h01);
    wr(ADDR_FAULT, 8'h01, 1'b0);
    wr(ADDR_LOGIC_EN, 8'h04, 1'b0);
    lng = 1'b1;
    conv(DAT);
    chk(res, DAT);
    chk(ca, c16(DAT, 128));
    chk(cla, c16({64'h0, DAT[127:64]}, 64));
    chk(clb, c16({64'h0, DAT[63:0]}, 64));
    wr(ADDR_LOGIC_EN, 8'h84, 1'b0);
    conv(DAT);
    chk(res, CHECK_PATTERN);
    chk(ca, c16(CHECK_PATTERN, 128));
    wr(ADDR_LEVEL_EN, 8'hff, 1'b1);
    rd(ADDR_FAULT, v);
    chk(v, 8'h04);
    rd(ADDR_LEVEL_EN, v);
    chk(v, 8'h00);
    wr(ADDR_FAULT, 8'h04, 1'b0);
    wr(ADDR_LOGIC_EN, 8'h20, 1'b0);
    lng = 1'b0;
    busy <= 1'b1;
    repeat (540) @(posedge mclk);
    busy <= 1'b0;
    chk(npr, 1);
    rd(ADDR_FAULT, v);
    chk(v, 8'h20);
    rd(ADDR_STATUS, v);
    chk(v, 8'hc0);
    wr(ADDR_FAULT, 8'h20, 1'b0);
    rp <= 1'b1;
    repeat (6) @(posedge mclk);
    rp <= 1'b0;
    rd(ADDR_STATUS, v);
    chk(v, 8'h80);
    chk(rm, 1'b1);
    wr(ADDR_EXIT, 8'h00, 1'b0);
    chk(rm, 1'b0);
    end_sim;
  end
endmodule // diagnostic_monitor_crc_flags_test
`default_nettype wire
